// File: verilog/supply_monitor_stop_recovery.sv
// supply supervision, brown-out reset and stop-mode recovery with apb registers
// Function
// - stop-recovery flag bit 7 set by hardware on recovery, cleared only by power-on
// - stop-recovery bits 6..0 write-only, bit 7 read-only
// - bit 6 picks low or high wake level at the comparison gate
// - bit 5 picks whether a reset delay follows recovery
// - bits 4..2 pick the wake source
// - bit 0 divides system and timer clock by 16
// - stop-recovery register decodes at offset 0B
// - watchdog bit 3, default 1, keeps watchdog running in stop on rc clock
// - global reset while below brown-out, then full power-on sequence
// - supply-detect bit 0 read/write enable, reset 0
// - supply flags valid only 20 us after enabling
// - bit 2 reads 1 only while supply above high threshold
// - bit 1 reads 1 only while supply below low threshold
// - low flag latches interrupt request bit 5 until cleared or reset
// - low-supply interrupt only when mask bit 5 enabled
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module supply_monitor_stop_recovery (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator pins
    input wire logic below_brownout,
    input wire logic above_high_supply,
    input wire logic below_low_supply,
    // stop mode
    input wire logic stop_req,
    input wire logic [7:0] wake_pins,
    // system outputs
    output logic sys_reset_n,
    output logic core_stopped,
    output logic recovery_reset,
    output logic clk_div16,
    output logic wdt_run_rc,
    output logic low_supply_irq
);
    logic rst_meta_q;
    logic rst_q;
    logic [supply_pkg::SYNC_WIDTH-1:0] pins_s;
    logic brown_s;
    logic high_s;
    logic low_s;
    logic [7:0] wake_s;
    logic settled;
    supply_pkg::por_state_t por_q, por_d;
    logic [9:0] por_cnt_q, por_cnt_d;
    supply_pkg::stop_state_t st_q, st_d;
    logic [7:0] dly_cnt_q, dly_cnt_d;
    logic rcv_flag_q, rcv_flag_d;
    logic [6:0] rcv_q, rcv_d;
    logic sdc_en_q, sdc_en_d;
    logic [7:0] wdm_q, wdm_d;
    logic [7:0] irq_q, irq_d;
    logic [7:0] msk_q, msk_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic sys_reset_n_q, core_stopped_q, recovery_reset_q, clk_div16_q, wdt_run_rc_q, low_supply_irq_q;
    logic por_active;
    logic wr;
    logic wake;
    logic low_set;
    logic [7:0] sdc_rd;

    localparam logic [9:0] POR_LAST = 10'(supply_pkg::POR_CYCLES - 1);
    localparam logic [7:0] DLY_LAST = 8'(supply_pkg::RECOVERY_DELAY_CYCLES - 1);

    function automatic logic known(input logic [11:0] a);
        known = (a == supply_pkg::ADDR_RCV) || (a == supply_pkg::ADDR_SDC) || (a == supply_pkg::ADDR_WDM)
             || (a == supply_pkg::ADDR_IRQ) || (a == supply_pkg::ADDR_MSK);
    endfunction : known

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end

    level_sync #(.WIDTH(supply_pkg::SYNC_WIDTH)) u_sync (
        .clk(clk),
        .rst_n(rst_q),
        .async_in({below_brownout, above_high_supply, below_low_supply, wake_pins}),
        .sync_out(pins_s)
    );
    assign brown_s = pins_s[10];
    assign high_s = pins_s[9];
    assign low_s = pins_s[8];
    assign wake_s = pins_s[7:0];

    settle_timer u_settle (
        .clk(clk),
        .rst_n(rst_q),
        .enable(sdc_en_q),
        .settled(settled)
    );

    // brown-out holds reset, then a full power-on count
    always_comb begin
        por_d = por_q;
        por_cnt_d = por_cnt_q;
        case (por_q)
            supply_pkg::POR_HOLD: begin
                if (brown_s) begin
                    por_cnt_d = 10'h000;
                end else if (por_cnt_q == POR_LAST) begin
                    por_d = supply_pkg::POR_RUN;
                end else begin
                    por_cnt_d = por_cnt_q + 10'h001;
                end
            end
            supply_pkg::POR_RUN: begin
                if (brown_s) begin
                    por_d = supply_pkg::POR_HOLD;
                    por_cnt_d = 10'h000;
                end
            end
            default: begin
                por_d = supply_pkg::POR_HOLD;
                por_cnt_d = 10'h000;
            end
        endcase
    end
    assign por_active = (por_q != supply_pkg::POR_RUN);

    // stop-mode recovery sequencing
    assign wake = (wake_s[rcv_q[supply_pkg::RCV_SRC_LO +: 3]] == rcv_q[supply_pkg::RCV_POL]);
    always_comb begin
        st_d = st_q;
        dly_cnt_d = dly_cnt_q;
        rcv_flag_d = rcv_flag_q;
        case (st_q)
            supply_pkg::ST_RUN: begin
                if (stop_req) begin
                    st_d = supply_pkg::ST_STOP;
                end
            end
            supply_pkg::ST_STOP: begin
                if (wake) begin
                    rcv_flag_d = 1'b1;
                    dly_cnt_d = 8'h00;
                    st_d = rcv_q[supply_pkg::RCV_DLY] ? supply_pkg::ST_DELAY : supply_pkg::ST_RUN;
                end
            end
            supply_pkg::ST_DELAY: begin
                if (dly_cnt_q == DLY_LAST) begin
                    st_d = supply_pkg::ST_RUN;
                end else begin
                    dly_cnt_d = dly_cnt_q + 8'h01;
                end
            end
            default: begin
                st_d = supply_pkg::ST_RUN;
            end
        endcase
        if (por_active) begin
            st_d = supply_pkg::ST_RUN;
            rcv_flag_d = 1'b0;
        end
    end

    // register file; no wait state, read data taken in the setup cycle leave a flop
    assign wr = psel && penable && pwrite && pready_q;
    assign low_set = sdc_en_q && settled && low_s;
    assign sdc_rd = {5'h00, high_s && sdc_en_q && settled, low_s && sdc_en_q && settled, sdc_en_q};
    always_comb begin
        rcv_d = rcv_q;
        sdc_en_d = sdc_en_q;
        wdm_d = wdm_q;
        irq_d = irq_q;
        msk_d = msk_q;
        prdata_d = prdata_q;
        pready_d = psel && !penable && !pready_q;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pslverr_d = !known(paddr);
            prdata_d = 32'h0000_0000;
            case (paddr)
                supply_pkg::ADDR_RCV: prdata_d[7:0] = {rcv_flag_q, 7'h00};
                supply_pkg::ADDR_SDC: prdata_d[7:0] = sdc_rd;
                supply_pkg::ADDR_WDM: prdata_d[7:0] = wdm_q;
                supply_pkg::ADDR_IRQ: prdata_d[7:0] = irq_q;
                supply_pkg::ADDR_MSK: prdata_d[7:0] = msk_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (paddr)
                supply_pkg::ADDR_RCV: rcv_d = pwdata[6:0];
                supply_pkg::ADDR_SDC: sdc_en_d = pwdata[supply_pkg::SDC_EN];
                supply_pkg::ADDR_WDM: wdm_d = pwdata[7:0];
                supply_pkg::ADDR_IRQ: irq_d = pwdata[7:0];
                supply_pkg::ADDR_MSK: msk_d = pwdata[7:0];
                default: ;
            endcase
        end
        // a low-supply event in the clearing cycle wins over the clear
        if (low_set) begin
            irq_d[supply_pkg::IRQ_LOW_SUPPLY] = 1'b1;
        end
        if (por_active) begin
            rcv_d = supply_pkg::RCV_RESET;
            sdc_en_d = supply_pkg::SDC_EN_RESET;
            wdm_d = supply_pkg::WDM_RESET;
            irq_d = supply_pkg::IRQ_RESET;
            msk_d = supply_pkg::MSK_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            por_q <= supply_pkg::POR_HOLD;
            por_cnt_q <= 10'h000;
            st_q <= supply_pkg::ST_RUN;
            dly_cnt_q <= 8'h00;
            rcv_flag_q <= 1'b0;
            rcv_q <= supply_pkg::RCV_RESET;
            sdc_en_q <= supply_pkg::SDC_EN_RESET;
            wdm_q <= supply_pkg::WDM_RESET;
            irq_q <= supply_pkg::IRQ_RESET;
            msk_q <= supply_pkg::MSK_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            sys_reset_n_q <= 1'b0;
            core_stopped_q <= 1'b0;
            recovery_reset_q <= 1'b0;
            clk_div16_q <= 1'b0;
            wdt_run_rc_q <= 1'b0;
            low_supply_irq_q <= 1'b0;
        end else begin
            por_q <= por_d;
            por_cnt_q <= por_cnt_d;
            st_q <= st_d;
            dly_cnt_q <= dly_cnt_d;
            rcv_flag_q <= rcv_flag_d;
            rcv_q <= rcv_d;
            sdc_en_q <= sdc_en_d;
            wdm_q <= wdm_d;
            irq_q <= irq_d;
            msk_q <= msk_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            sys_reset_n_q <= (por_d == supply_pkg::POR_RUN);
            core_stopped_q <= (st_d == supply_pkg::ST_STOP);
            recovery_reset_q <= (st_d == supply_pkg::ST_DELAY);
            clk_div16_q <= rcv_d[supply_pkg::RCV_DIV16];
            // crystal is stopped in stop, so the watchdog must run from rc
            wdt_run_rc_q <= (st_d == supply_pkg::ST_STOP) && wdm_d[supply_pkg::WDM_STOP_RUN];
            low_supply_irq_q <= irq_d[supply_pkg::IRQ_LOW_SUPPLY] && msk_d[supply_pkg::IRQ_LOW_SUPPLY];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sys_reset_n = sys_reset_n_q;
    assign core_stopped = core_stopped_q;
    assign recovery_reset = recovery_reset_q;
    assign clk_div16 = clk_div16_q;
    assign wdt_run_rc = wdt_run_rc_q;
    assign low_supply_irq = low_supply_irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q);

    sequence s_wake_in_stop;
        (st_q == supply_pkg::ST_STOP) && wake && !por_active;
    endsequence
    sequence s_delayed_exit;
        recovery_reset_q [*2];
    endsequence

    property p_flag_set;
        s_wake_in_stop |=> rcv_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("recovery flag not set");
    property p_rcv_read;
        psel && !penable && (paddr == supply_pkg::ADDR_RCV) |=> (prdata_q[6:0] == 7'h00) && pready_q;
    endproperty
    a_rcv_read: assert property (p_rcv_read) else $error("write-only bits leaked");
    property p_stay_stopped;
        (st_q == supply_pkg::ST_STOP) && !wake && !por_active |=> core_stopped_q;
    endproperty
    a_stay_stopped: assert property (p_stay_stopped) else $error("woke on wrong level");
    property p_delay;
        s_wake_in_stop ##0 rcv_q[supply_pkg::RCV_DLY] |=> s_delayed_exit;
    endproperty
    a_delay: assert property (p_delay) else $error("recovery delay missing");
    property p_div16;
        ##1 clk_div16_q == $past(rcv_d[supply_pkg::RCV_DIV16]);
    endproperty
    a_div16: assert property (p_div16) else $error("divide output wrong");
    property p_wdt;
        wdt_run_rc_q |-> core_stopped_q && $past(wdm_d[supply_pkg::WDM_STOP_RUN]);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stop mode wrong");
    property p_brownout;
        brown_s |=> !sys_reset_n_q ##1 !sys_reset_n_q;
    endproperty
    a_brownout: assert property (p_brownout) else $error("no reset under brown-out");
    property p_flag_valid;
        !settled |-> (sdc_rd[2:1] == 2'b00);
    endproperty
    a_flag_valid: assert property (p_flag_valid) else $error("flags shown before settling");
    property p_irq_latch;
        irq_q[supply_pkg::IRQ_LOW_SUPPLY] && !wr && !por_active |=> irq_q[supply_pkg::IRQ_LOW_SUPPLY];
    endproperty
    a_irq_latch: assert property (p_irq_latch) else $error("request bit lost");
    property p_mask;
        ##1 low_supply_irq_q == ($past(irq_d[supply_pkg::IRQ_LOW_SUPPLY]) && $past(msk_d[supply_pkg::IRQ_LOW_SUPPLY]));
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt not gated by mask");
    property p_sdc_upper;
        psel && !penable && (paddr == supply_pkg::ADDR_SDC) |=> (prdata_q[7:3] == 5'h00);
    endproperty
    a_sdc_upper: assert property (p_sdc_upper) else $error("reserved bits nonzero");
endmodule : supply_monitor_stop_recovery

// File: verilog/supply_pkg.sv
// constants shared by the supply monitor and stop-recovery block
package supply_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RCV = 8'h0B;
    localparam logic [7:0] IDX_SDC = 8'h0C;
    localparam logic [7:0] IDX_WDM = 8'h0D;
    localparam logic [7:0] IDX_IRQ = 8'hFA;
    localparam logic [7:0] IDX_MSK = 8'hFB;
    localparam logic [11:0] ADDR_RCV = {2'h0, IDX_RCV, 2'h0};
    localparam logic [11:0] ADDR_SDC = {2'h0, IDX_SDC, 2'h0};
    localparam logic [11:0] ADDR_WDM = {2'h0, IDX_WDM, 2'h0};
    localparam logic [11:0] ADDR_IRQ = {2'h0, IDX_IRQ, 2'h0};
    localparam logic [11:0] ADDR_MSK = {2'h0, IDX_MSK, 2'h0};
    // stop-recovery control fields
    localparam int RCV_FLAG = 7;
    localparam int RCV_POL = 6;
    localparam int RCV_DLY = 5;
    localparam int RCV_SRC_LO = 2;
    localparam int RCV_DIV16 = 0;
    localparam logic [6:0] RCV_RESET = 7'h20;
    // supply-detect control fields
    localparam int SDC_HIGH = 2;
    localparam int SDC_LOW = 1;
    localparam int SDC_EN = 0;
    localparam logic SDC_EN_RESET = 1'b0;
    // watchdog mode, interrupt request and mask fields
    localparam int WDM_STOP_RUN = 3;
    localparam logic [7:0] WDM_RESET = 8'h08;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] MSK_RESET = 8'h00;
    localparam int IRQ_LOW_SUPPLY = 5;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_US = 20;
    localparam int POR_US = 40;
    localparam int RECOVERY_DELAY_US = 10;
    localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CYCLES = (POR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_DELAY_CYCLES = (RECOVERY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_WIDTH = 11;
    typedef enum logic [1:0] {
        POR_HOLD = 2'b01,
        POR_RUN = 2'b10
    } por_state_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_STOP = 3'b010,
        ST_DELAY = 3'b100
    } stop_state_t;
endpackage : supply_pkg

// File: verilog/level_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : level_sync

// File: verilog/settle_timer.sv
// counts the settling interval after supply monitoring is switched on
`timescale 1ns/100ps
module settle_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    output logic settled
);
    localparam logic [9:0] LAST = 10'(supply_pkg::SETTLE_CYCLES - 1);
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic done_q;
    logic done_d;

    // disabling restarts the wait, so a quick off/on never shows stale flags
    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (!enable) begin
            cnt_d = 10'h000;
            done_d = 1'b0;
        end else if (!done_q) begin
            if (cnt_q == LAST) begin
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 10'h000;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign settled = done_q;
endmodule : settle_timer

// File: bench/supply_monitor_stop_recovery_test.sv
// self-checking bench for supply monitor and stop-recovery block
`timescale 1ns/100ps
module supply_monitor_stop_recovery_test;
    // clock and reset
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    // apb
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // comparator pins and stop
    logic below_brownout = 1'b0;
    logic above_high_supply = 1'b0;
    logic below_low_supply = 1'b0;
    logic stop_req = 1'b0;
    logic [7:0] wake_pins = 8'h00;
    // system outputs
    logic sys_reset_n;
    logic core_stopped;
    logic recovery_reset;
    logic clk_div16;
    logic wdt_run_rc;
    logic low_supply_irq;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [32:0] exp_q[$];

    supply_monitor_stop_recovery i_dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .below_brownout(below_brownout), .above_high_supply(above_high_supply),
        .below_low_supply(below_low_supply), .stop_req(stop_req), .wake_pins(wake_pins),
        .sys_reset_n(sys_reset_n), .core_stopped(core_stopped), .recovery_reset(recovery_reset),
        .clk_div16(clk_div16), .wdt_run_rc(wdt_run_rc), .low_supply_irq(low_supply_irq)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    // read monitor: oldest note against completed read
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                check({pslverr, prdata}, 33'h1FFFFFFFF);
            end else begin
                check({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    // one apb transfer; upper write bits random, ignored by the block
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [32:0] exp);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($urandom()), d};
        if (!wr) begin
            exp_q.push_back(exp);
        end
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no wait-state count assumed; only the hang guard ends this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // waits for an output to reach a level; sel 0 reset, 1 stopped
    task automatic wait_sig(input int sel, input logic lvl, input int max);
        int n;
        n = 0;
        while (((sel == 0) ? sys_reset_n : core_stopped) !== lvl && n < max) begin
            n++;
            @(posedge clk);
        end
        check(((sel == 0) ? sys_reset_n : core_stopped), lvl);
    endtask : wait_sig

    task automatic do_stop;
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        wait_sig(1, 1'b1, 5);
    endtask : do_stop

    initial begin
        int n;
        void'($urandom(81673));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        wait_sig(0, 1'b1, 1200);
        // reset values, write-only bits read zero
        apb(0, supply_pkg::ADDR_RCV, 8'h00, 33'h000000000);
        apb(0, supply_pkg::ADDR_SDC, 8'h00, 33'h000000000);
        apb(0, supply_pkg::ADDR_WDM, 8'h00, 33'h000000008);
        apb(0, supply_pkg::ADDR_IRQ, 8'h00, 33'h000000000);
        apb(0, supply_pkg::ADDR_MSK, 8'h00, 33'h000000000);
        apb(0, 12'h000, 8'h00, 33'h100000000);
        apb(1, supply_pkg::ADDR_RCV, 8'h7F, 33'h0);
        apb(0, supply_pkg::ADDR_RCV, 8'h00, 33'h000000000);
        check(clk_div16, 1'b1);
        apb(1, supply_pkg::ADDR_RCV, 8'h00, 33'h0);
        // the write lands on this edge; look one edge later
        @(posedge clk);
        check(clk_div16, 1'b0);
        // supply detect: enable, flags hidden until settled; no port mode writes here
        below_low_supply <= 1'b1;
        apb(1, supply_pkg::ADDR_SDC, 8'hFF, 33'h0); // global enable is the core's
        apb(0, supply_pkg::ADDR_SDC, 8'h00, 33'h000000001);
        repeat (supply_pkg::SETTLE_CYCLES + 20) @(posedge clk);
        apb(0, supply_pkg::ADDR_SDC, 8'h00, 33'h000000003);
        apb(0, supply_pkg::ADDR_IRQ, 8'h00, 33'h000000020);
        check(low_supply_irq, 1'b0);
        apb(1, supply_pkg::ADDR_MSK, 8'h20, 33'h0); // core interrupts off here
        repeat (3) @(posedge clk);
        check(low_supply_irq, 1'b1);
        below_low_supply <= 1'b0;
        above_high_supply <= 1'b1;
        repeat (5) @(posedge clk);
        apb(0, supply_pkg::ADDR_SDC, 8'h00, 33'h000000005);
        apb(0, supply_pkg::ADDR_IRQ, 8'h00, 33'h000000020);
        apb(1, supply_pkg::ADDR_IRQ, 8'h00, 33'h0);
        apb(0, supply_pkg::ADDR_IRQ, 8'h00, 33'h000000000);
        repeat (3) @(posedge clk);
        check(low_supply_irq, 1'b0);
        apb(1, supply_pkg::ADDR_SDC, 8'h00, 33'h0);
        // stop with high wake level, delay, source 3
        wake_pins <= 8'($urandom()) & 8'hF7;
        apb(1, supply_pkg::ADDR_RCV, 8'h6C, 33'h0);
        do_stop();
        check(wdt_run_rc, 1'b1);
        wake_pins <= 8'hF7;
        repeat (10) @(posedge clk);
        check(core_stopped, 1'b1);
        wake_pins <= 8'h08;
        wait_sig(1, 1'b0, 10);
        n = 0;
        while (recovery_reset === 1'b1 && n < 400) begin
            n++;
            @(posedge clk);
        end
        check(33'(n), 33'(supply_pkg::RECOVERY_DELAY_CYCLES));
        apb(0, supply_pkg::ADDR_RCV, 8'h00, 33'h000000080);
        // stop with low wake level, no delay, source 5, watchdog off in stop
        wake_pins <= 8'($urandom()) | 8'h20;
        apb(1, supply_pkg::ADDR_WDM, 8'h00, 33'h0);
        apb(1, supply_pkg::ADDR_RCV, 8'h14, 33'h0);
        do_stop();
        check(wdt_run_rc, 1'b0);
        wake_pins <= 8'h00;
        wait_sig(1, 1'b0, 10);
        repeat (3) @(posedge clk);
        check(recovery_reset, 1'b0);
        apb(0, supply_pkg::ADDR_RCV, 8'h00, 33'h000000080);
        // brown-out forces reset then a full power-on count
        @(posedge clk);
        below_brownout <= 1'b1;
        wait_sig(0, 1'b0, 10);
        repeat (20) @(posedge clk);
        below_brownout <= 1'b0;
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 1200) begin
            n++;
            @(posedge clk);
        end
        check(n >= supply_pkg::POR_CYCLES && n < 1200, 1'b1);
        apb(0, supply_pkg::ADDR_RCV, 8'h00, 33'h000000000);
        apb(0, supply_pkg::ADDR_MSK, 8'h00, 33'h000000000);
        apb(0, supply_pkg::ADDR_WDM, 8'h00, 33'h000000008);
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule : supply_monitor_stop_recovery_test
